/* shared/msp_pkg.sv */
package msp_pkg;

  // datapath widths
  localparam int A_W   = 30;
  localparam int B_W   = 24;
  localparam int C_W   = 58;
  localparam int D_W   = 27;
  localparam int MA_W  = 27;
  localparam int M_W   = 51;
  localparam int P_W   = 58;
  localparam int OP_W  = 9;
  localparam int ALU_W = 4;
  localparam int CS_W  = 3;
  localparam int IM_W  = 5;
  localparam int CO_W  = 4;

  // adder lane split
  localparam int LANE_W = 12;
  localparam int LANE_N = 4;
  localparam int TOP_W  = P_W - LANE_N * LANE_W;

  // deepest a or b input pipeline
  localparam int MAX_PIPE = 2;

  // value every pipeline register takes on reset
  localparam logic STAGE_RST_BIT = 1'b0;

  // adder lane modes
  localparam logic [1:0] SIMD_ONE  = 2'h0;
  localparam logic [1:0] SIMD_TWO  = 2'h1;
  localparam logic [1:0] SIMD_FOUR = 2'h2;

  // positions in the enable-port usage mask
  localparam int A_STAGE1_ENABLE  = 0;
  localparam int A_STAGE2_ENABLE  = 1;
  localparam int B_STAGE1_ENABLE  = 2;
  localparam int B_STAGE2_ENABLE  = 3;
  localparam int CE_C   = 4;
  localparam int CE_M   = 5;
  localparam int CE_P   = 6;
  localparam int CE_CIN = 7;
  localparam int CE_ALU = 8;
  localparam int CE_CTL = 9;
  localparam int CE_D   = 10;
  localparam int CE_AD  = 11;
  localparam int CE_IM  = 12;
  localparam int CE_N   = 13;

  // positions in the reset-port usage mask
  localparam int RS_A   = 0;
  localparam int RS_B   = 1;
  localparam int RS_C   = 2;
  localparam int RS_M   = 3;
  localparam int RS_P   = 4;
  localparam int RS_CIN = 5;
  localparam int RS_ALU = 6;
  localparam int RS_CTL = 7;
  localparam int RS_D   = 8;
  localparam int RS_IM  = 9;
  localparam int RS_GLB = 10;
  localparam int RS_N   = 11;

  // operand mux codes (x: opmode[1:0], y: [3:2], z: [5:4])
  localparam logic [1:0] SEL_ZERO = 2'h0;
  localparam logic [1:0] X_M      = 2'h1;
  localparam logic [1:0] X_P      = 2'h2;
  localparam logic [1:0] X_AB     = 2'h3;
  localparam logic [1:0] Y_C      = 2'h1;
  localparam logic [1:0] Y_PCIN   = 2'h2;
  localparam logic [1:0] Z_PCIN   = 2'h1;
  localparam logic [1:0] Z_P      = 2'h2;
  localparam logic [1:0] Z_C      = 2'h3;

  // logic unit function, alumode[3:2]
  localparam logic [1:0] LU_ARITH = 2'h0;
  localparam logic [1:0] LU_XOR   = 2'h1;
  localparam logic [1:0] LU_AND   = 2'h2;
  localparam logic [1:0] LU_OR    = 2'h3;

  // carry source select codes
  localparam logic [2:0] CSEL_CARRYIN = 3'h0;
  localparam logic [2:0] CSEL_PSIGN   = 3'h1;

  // inmode bit positions
  localparam int IM_USE_D = 2;
  localparam int IM_SUB_D = 3;

endpackage : msp_pkg

/* hdl/msp_stage.sv */
`timescale 1ns/100ps
`default_nettype none

module msp_stage #(
  parameter int W       = 1,
  parameter bit PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // synchronous controls
  input  wire logic         sync_rst,
  input  wire logic         enable,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import msp_pkg::*;

  typedef struct packed {
    logic [W-1:0] val;            // held word
  } msp_stage_t;

  msp_stage_t st_q;               // registered state
  msp_stage_t st_d;               // next state

  always_comb begin
    st_d = st_q;
    if (sync_rst) begin
      // sync clear wins even with enable low
      st_d.val = {W{STAGE_RST_BIT}};
    end else if (enable) begin
      st_d.val = din;
    end
  end

  // single register of the whole state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  generate
    if (PRESENT) begin : g_reg
      assign dout = st_q.val;

      sequence s_clear;
        sync_rst ##1 (dout == '0);
      endsequence

      a_sync_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        sync_rst |-> s_clear)
        else $error("stage not cleared after sync reset");

      a_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!sync_rst && !enable) |=> (dout == $past(dout)))
        else $error("stage changed with enable low");

      a_load_word: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!sync_rst && enable) |=> (dout == $past(din)))
        else $error("stage missed load on enable");
    end else begin : g_wire
      // bypass: flops left unread and trimmed away
      assign dout = din;
    end
  endgenerate

endmodule : msp_stage

`default_nettype wire

/* hdl/msp_slice.sv */
`timescale 1ns/100ps
`default_nettype none

module msp_slice #(
  parameter int             AREG      = 2,      // a pipeline length 0..2
  parameter int             BREG      = 2,      // b pipeline length 0..2
  parameter int             ACASCREG  = 2,      // acout tap length
  parameter int             BCASCREG  = 2,      // bcout tap length
  parameter bit             A_CASC_IN = 1'b0,   // take a from acin
  parameter bit             B_CASC_IN = 1'b0,   // take b from bcin
  parameter bit             CREG      = 1'b1,
  parameter bit             MREG      = 1'b1,
  parameter bit             PREG      = 1'b1,
  parameter bit             OPREG     = 1'b1,
  parameter bit             ALUREG    = 1'b1,
  parameter bit             CINREG    = 1'b1,
  parameter bit             CSELREG   = 1'b1,
  parameter bit             DREG      = 1'b1,
  parameter bit             ADREG     = 1'b1,
  parameter bit             IMREG     = 1'b1,
  parameter logic [1:0]     SIMD_MODE = 2'h0,   // lane mode code
  parameter logic [12:0]    CE_USE    = '1,     // enable ports in use
  parameter logic [10:0]    RST_USE   = '1,     // reset ports in use
  parameter logic [8:0]     INV_OP    = '0,     // opmode bits to invert
  parameter logic [3:0]     INV_ALU   = '0,     // alumode bits to invert
  parameter bit             INV_CIN   = 1'b0,   // invert carry in
  parameter logic [4:0]     INV_IM    = '0      // inmode bits to invert
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  // operands
  input  wire logic [msp_pkg::A_W-1:0]      a,
  input  wire logic [msp_pkg::A_W-1:0]      acin,
  input  wire logic [msp_pkg::B_W-1:0]      b,
  input  wire logic [msp_pkg::B_W-1:0]      bcin,
  input  wire logic [msp_pkg::C_W-1:0]      c,
  input  wire logic [msp_pkg::D_W-1:0]      d,
  input  wire logic [msp_pkg::P_W-1:0]      pcin,
  // controls
  input  wire logic [msp_pkg::OP_W-1:0]     opmode,
  input  wire logic [msp_pkg::ALU_W-1:0]    alumode,
  input  wire logic                         carry_in,
  input  wire logic [msp_pkg::CS_W-1:0]     carry_in_sel,
  input  wire logic [msp_pkg::IM_W-1:0]     inmode,
  // synchronous resets, active high
  input  wire logic                         global_rst,
  input  wire logic                         rst_a,
  input  wire logic                         rst_b,
  input  wire logic                         rst_c,
  input  wire logic                         rst_m,
  input  wire logic                         rst_p,
  input  wire logic                         rst_carryin,
  input  wire logic                         rst_alumode,
  input  wire logic                         rst_ctrl,
  input  wire logic                         rst_d,
  input  wire logic                         rst_inmode,
  // clock enables, active high
  input  wire logic                         a_stage1_enable,
  input  wire logic                         a_stage2_enable,
  input  wire logic                         b_stage1_enable,
  input  wire logic                         b_stage2_enable,
  input  wire logic                         c_enable,
  input  wire logic                         m_enable,
  input  wire logic                         p_enable,
  input  wire logic                         carry_in_enable,
  input  wire logic                         alumode_enable,
  input  wire logic                         ctrl_enable,
  input  wire logic                         d_enable,
  input  wire logic                         ad_enable,
  input  wire logic                         inmode_enable,
  // results and cascades
  output logic      [msp_pkg::P_W-1:0]      p,
  output logic      [msp_pkg::P_W-1:0]      pcout,
  output logic      [msp_pkg::A_W-1:0]      acout,
  output logic      [msp_pkg::B_W-1:0]      bcout,
  output logic      [msp_pkg::CO_W-1:0]     carryout
);
  import msp_pkg::*;

  // tap never deeper than its pipeline
  localparam int ACAS_EFF = (ACASCREG > AREG) ? AREG : ACASCREG;
  // same cap on the b side
  localparam int BCAS_EFF = (BCASCREG > BREG) ? BREG : BCASCREG;

  // enable from port, or always on when the port is unused
  function automatic logic ce_pick(input logic used, input logic port_val);
    return used ? port_val : 1'b1;
  endfunction : ce_pick

  // global reset, when its port is in use, folds into every register's reset
  function automatic logic rst_pick(input logic used, input logic port_val);
    return (used & port_val) | (RST_USE[RS_GLB] & global_rst);
  endfunction : rst_pick

  // add u and v in lanes; returns {carry bits, sum}
  function automatic logic [P_W+CO_W-1:0] lane_add(
    input logic [P_W-1:0] u,
    input logic [P_W-1:0] v,
    input logic           cin0,
    input logic           cin_lane,
    input logic [1:0]     mode
  );
    logic [LANE_W:0]   t;
    logic [TOP_W:0]    tt;
    logic              cy;
    logic              brk;
    logic [P_W-1:0]    s;
    logic [CO_W-1:0]   co;
    cy  = cin0;
    s   = '0;
    co  = '0;
    t   = '0;
    brk = 1'b0;
    for (int k = 0; k < LANE_N; k++) begin
      // lane boundary: carry is cut and restarted
      brk = (k != 0) && ((mode == SIMD_FOUR) || ((mode == SIMD_TWO) && (k == 2)));
      if (brk) begin
        cy = cin_lane;
      end
      t = {1'b0, u[k*LANE_W +: LANE_W]} + {1'b0, v[k*LANE_W +: LANE_W]}
          + {{LANE_W{1'b0}}, cy};
      s[k*LANE_W +: LANE_W] = t[LANE_W-1:0];
      cy = t[LANE_W];
      if (mode == SIMD_FOUR) begin
        co[k] = cy;
      end else if ((mode == SIMD_TWO) && (k == 1)) begin
        co[0] = cy;
      end else if ((mode == SIMD_TWO) && (k == 3)) begin
        co[1] = cy;
      end
    end
    // top bits only chain on in the full-width mode
    cy = (mode == SIMD_ONE) ? cy : 1'b0;
    tt = {1'b0, u[P_W-1:LANE_N*LANE_W]} + {1'b0, v[P_W-1:LANE_N*LANE_W]}
         + {{TOP_W{1'b0}}, cy};
    s[P_W-1:LANE_N*LANE_W] = tt[TOP_W-1:0];
    if (mode == SIMD_ONE) begin
      co[0] = tt[TOP_W];
    end
    return {co, s};
  endfunction : lane_add

  // operand a and b pipeline taps, index = stages passed
  logic [A_W-1:0]   a_tap [0:MAX_PIPE];
  logic [B_W-1:0]   b_tap [0:MAX_PIPE];
  // registered control and operand words
  logic [C_W-1:0]   c_q;
  logic [D_W-1:0]   d_q;
  logic [MA_W-1:0]  ad_q;
  logic [M_W-1:0]   m_q;
  logic [OP_W-1:0]  op_q;
  logic [ALU_W-1:0] alu_q;
  logic             cin_q;
  logic [CS_W-1:0]  csel_q;
  logic [IM_W-1:0]  im_q;
  // combinational datapath
  logic [MA_W-1:0]  ad_w;
  logic [MA_W-1:0]  mult_a;
  logic [M_W-1:0]   m_w;
  logic [P_W-1:0]   x_w;
  logic [P_W-1:0]   y_w;
  logic [P_W-1:0]   z_w;
  logic             cy_w;
  logic [P_W+CO_W-1:0] sum1;
  logic [P_W+CO_W-1:0] sum2;
  logic [P_W-1:0]   res_w;
  logic [CO_W-1:0]  co_w;
  logic [P_W+CO_W-1:0] p_stage;

  // b and bcin share one pipeline
  assign a_tap[0] = A_CASC_IN ? acin : a;
  assign b_tap[0] = B_CASC_IN ? bcin : b;

  // a stages exist only up to the set length
  generate
    for (genvar i = 1; i <= MAX_PIPE; i++) begin : g_pipe
      if (i <= AREG) begin : g_a
        // each a stage has its own enable
        msp_stage #(.W(A_W), .PRESENT(1'b1)) u_a (
          .sys_clk  (sys_clk),
          .resetn   (resetn),
          // a reset clears every a stage
          .sync_rst (rst_pick(RST_USE[RS_A], rst_a)),
          .enable   ((i == 1) ? ce_pick(CE_USE[A_STAGE1_ENABLE], a_stage1_enable)
                              : ce_pick(CE_USE[A_STAGE2_ENABLE], a_stage2_enable)),
          .din      (a_tap[i-1]),
          .dout     (a_tap[i])
        );
      end else begin : g_a_thru
        assign a_tap[i] = a_tap[i-1];
      end
      if (i <= BREG) begin : g_b
        // each b stage has its own enable
        msp_stage #(.W(B_W), .PRESENT(1'b1)) u_b (
          .sys_clk  (sys_clk),
          .resetn   (resetn),
          // b reset clears every b stage
          .sync_rst (rst_pick(RST_USE[RS_B], rst_b)),
          .enable   ((i == 1) ? ce_pick(CE_USE[B_STAGE1_ENABLE], b_stage1_enable)
                              : ce_pick(CE_USE[B_STAGE2_ENABLE], b_stage2_enable)),
          .din      (b_tap[i-1]),
          .dout     (b_tap[i])
        );
      end else begin : g_b_thru
        assign b_tap[i] = b_tap[i-1];
      end
    end
  endgenerate

  // acout taps the a chain at its own depth
  assign acout = a_tap[ACAS_EFF];
  // bcout taps the b chain at its own depth
  assign bcout = b_tap[BCAS_EFF];

  msp_stage #(.W(C_W), .PRESENT(CREG)) u_c (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_C], rst_c)),
    .enable   (ce_pick(CE_USE[CE_C], c_enable)),
    .din      (c),
    .dout     (c_q)
  );

  // opmode register, inverted bits applied first
  msp_stage #(.W(OP_W), .PRESENT(OPREG)) u_op (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_CTL], rst_ctrl)),
    .enable   (ce_pick(CE_USE[CE_CTL], ctrl_enable)),
    .din      (opmode ^ INV_OP),
    .dout     (op_q)
  );

  msp_stage #(.W(CS_W), .PRESENT(CSELREG)) u_csel (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_CTL], rst_ctrl)),
    .enable   (ce_pick(CE_USE[CE_CTL], ctrl_enable)),
    .din      (carry_in_sel),
    .dout     (csel_q)
  );

  msp_stage #(.W(ALU_W), .PRESENT(ALUREG)) u_alu (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_ALU], rst_alumode)),
    .enable   (ce_pick(CE_USE[CE_ALU], alumode_enable)),
    .din      (alumode ^ INV_ALU),
    .dout     (alu_q)
  );

  // carry in inverted before its register
  msp_stage #(.W(1), .PRESENT(CINREG)) u_cin (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_CIN], rst_carryin)),
    .enable   (ce_pick(CE_USE[CE_CIN], carry_in_enable)),
    .din      (carry_in ^ INV_CIN),
    .dout     (cin_q)
  );

  msp_stage #(.W(IM_W), .PRESENT(IMREG)) u_im (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_IM], rst_inmode)),
    .enable   (ce_pick(CE_USE[CE_IM], inmode_enable)),
    .din      (inmode ^ INV_IM),
    .dout     (im_q)
  );

  msp_stage #(.W(D_W), .PRESENT(DREG)) u_d (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_D], rst_d)),
    .enable   (ce_pick(CE_USE[CE_D], d_enable)),
    .din      (d),
    .dout     (d_q)
  );

  // pre-adder: d plus or minus the low a bits
  always_comb begin
    if (im_q[IM_SUB_D]) begin
      ad_w = MA_W'(d_q - a_tap[AREG][MA_W-1:0]);
    end else begin
      ad_w = MA_W'(d_q + a_tap[AREG][MA_W-1:0]);
    end
  end

  // pre-adder result register, cleared with d
  msp_stage #(.W(MA_W), .PRESENT(ADREG)) u_ad (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_D], rst_d)),
    .enable   (ce_pick(CE_USE[CE_AD], ad_enable)),
    .din      (ad_w),
    .dout     (ad_q)
  );

  // signed multiply of a (or pre-sum) by b
  assign mult_a = im_q[IM_USE_D] ? ad_q : a_tap[AREG][MA_W-1:0];
  assign m_w    = M_W'($signed(mult_a) * $signed(b_tap[BREG]));

  msp_stage #(.W(M_W), .PRESENT(MREG)) u_m (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_M], rst_m)),
    .enable   (ce_pick(CE_USE[CE_M], m_enable)),
    .din      (m_w),
    .dout     (m_q)
  );

  // operand muxes and carry source
  always_comb begin
    case (op_q[1:0])
      X_M:     x_w = {{(P_W-M_W){m_q[M_W-1]}}, m_q};
      X_P:     x_w = p;
      X_AB:    x_w = {{(P_W-A_W-B_W){1'b0}}, a_tap[AREG], b_tap[BREG]};
      default: x_w = '0;
    endcase
    case (op_q[3:2])
      Y_C:     y_w = c_q;
      Y_PCIN:  y_w = pcin;
      default: y_w = '0;
    endcase
    case (op_q[5:4])
      Z_PCIN:  z_w = pcin;
      Z_P:     z_w = p;
      Z_C:     z_w = c_q;
      default: z_w = '0;
    endcase
    // rounding trick: inverted p sign feeds the carry when chosen
    case (csel_q)
      CSEL_CARRYIN: cy_w = cin_q;
      CSEL_PSIGN:   cy_w = ~p[P_W-1];
      default:      cy_w = 1'b0;
    endcase
  end

  // adder runs in the configured lane split
  always_comb begin
    sum1 = lane_add(x_w, y_w, cy_w, 1'b0, SIMD_MODE);
    if (alu_q[0]) begin
      // z minus (x + y + carry): each lane adds its own one
      sum2 = lane_add(z_w, ~sum1[P_W-1:0], 1'b1, 1'b1, SIMD_MODE);
    end else begin
      sum2 = lane_add(z_w, sum1[P_W-1:0], 1'b0, 1'b0, SIMD_MODE);
    end
    case (alu_q[3:2])
      LU_XOR:  res_w = x_w ^ z_w;
      LU_AND:  res_w = x_w & z_w;
      LU_OR:   res_w = x_w | z_w;
      default: res_w = sum2[P_W-1:0];
    endcase
    // unused carry bits stay low per mode
    if (alu_q[3:2] != LU_ARITH) begin
      co_w = '0;
    end else if (alu_q[0]) begin
      co_w = sum2[P_W+CO_W-1:P_W];
    end else begin
      // two stacked adds: either one may carry
      co_w = sum1[P_W+CO_W-1:P_W] | sum2[P_W+CO_W-1:P_W];
    end
  end

  // one register feeds p, pcout and carry out
  msp_stage #(.W(P_W+CO_W), .PRESENT(PREG)) u_p (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .sync_rst (rst_pick(RST_USE[RS_P], rst_p)),
    .enable   (ce_pick(CE_USE[CE_P], p_enable)),
    .din      ({co_w, res_w}),
    .dout     (p_stage)
  );

  assign p        = p_stage[P_W-1:0];
  assign pcout    = p_stage[P_W-1:0];
  assign carryout = p_stage[P_W+CO_W-1:P_W];

  a_p_pcout_pair: assert property (@(posedge sys_clk) disable iff (!resetn)
    p == pcout)
    else $error("p and pcout differ");

  a_carry_width: assert property (@(posedge sys_clk) disable iff (!resetn)
    (SIMD_MODE == SIMD_ONE) |-> (carryout[3:1] == 3'h0))
    else $error("upper carry bits set in full-width mode");

  a_carry_two: assert property (@(posedge sys_clk) disable iff (!resetn)
    (SIMD_MODE == SIMD_TWO) |-> (carryout[3:2] == 2'h0))
    else $error("carry bits above two lanes set");

  generate
    if (AREG == 0) begin : g_chk_abyp
      a_a_bypass: assert property (@(posedge sys_clk) disable iff (!resetn)
        a_tap[AREG] == (A_CASC_IN ? acin : a))
        else $error("a path not bypassed at length zero");
    end
    if (OPREG && CSELREG) begin : g_chk_ctl
      a_ctrl_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        (RST_USE[RS_CTL] && rst_ctrl) |=> ((op_q == '0) && (csel_q == '0)))
        else $error("control reset left opmode or select set");
    end
    if (PREG) begin : g_chk_p
      a_p_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        (CE_USE[CE_P] && !p_enable && !rst_pick(RST_USE[RS_P], rst_p))
          |=> (p == $past(p)) && (carryout == $past(carryout)))
        else $error("p moved with its enable low");
    end
  endgenerate

endmodule : msp_slice

`default_nettype wire

/* verif/msp_fabric_model.sv */
`timescale 1ns/100ps
`default_nettype none
// neighbour slice: hands the slice's pcout back, one register later, as the cascade input
module msp_fabric_model (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  // cascade
  input  wire logic [msp_pkg::P_W-1:0] pcout,
  output logic      [msp_pkg::P_W-1:0] pcin
);
  import msp_pkg::*;
  // one register stage, as the neighbour's own output register would add
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pcin <= '0;
    end else begin
      pcin <= pcout;
    end
  end
endmodule : msp_fabric_model
`default_nettype wire

/* verif/mac_slice_pipeline_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_slice_pipeline_regs_test;
  import msp_pkg::*;
  logic sys_clk, resetn;
  logic [A_W-1:0] a, acin, acout;
  logic [B_W-1:0] b, bcin, bcout;
  logic [C_W-1:0] c;
  logic [D_W-1:0] d;
  logic [P_W-1:0] pcin, p, pcout;
  logic [8:0] op;
  logic [3:0] alu, co;
  logic [2:0] csel;
  logic [4:0] im;
  logic cin;
  logic [12:0] en;
  logic [10:0] rs;
  int failures, cmp_count;
  // product rows: operands beside the result they give
  logic [A_W+B_W+P_W-1:0] rows [4] = '{{30'h3, 24'h5, 58'hF},
    {30'h7FF, 24'h100, 58'h7FF00}, {30'h0, 24'hABC, 58'h0}, {30'h3E8, 24'h3E8, 58'hF4240}};
  msp_slice dut (.sys_clk(sys_clk), .resetn(resetn), .a(a), .acin(acin), .b(b),
    .bcin(bcin), .c(c), .d(d), .pcin(pcin), .opmode(op), .alumode(alu), .carry_in(cin),
    .carry_in_sel(csel), .inmode(im), .global_rst(rs[10]), .rst_a(rs[0]), .rst_b(rs[1]),
    .rst_c(rs[2]), .rst_m(rs[3]), .rst_p(rs[4]), .rst_carryin(rs[5]),
    .rst_alumode(rs[6]), .rst_ctrl(rs[7]), .rst_d(rs[8]), .rst_inmode(rs[9]),
    .a_stage1_enable(en[0]), .a_stage2_enable(en[1]), .b_stage1_enable(en[2]),
    .b_stage2_enable(en[3]), .c_enable(en[4]), .m_enable(en[5]), .p_enable(en[6]),
    .carry_in_enable(en[7]), .alumode_enable(en[8]), .ctrl_enable(en[9]),
    .d_enable(en[10]), .ad_enable(en[11]), .inmode_enable(en[12]), .p(p),
    .pcout(pcout), .acout(acout), .bcout(bcout), .carryout(co));
  msp_fabric_model nb (.sys_clk(sys_clk), .resetn(resetn), .pcout(pcout), .pcin(pcin));
  // compare one value and count it
  task automatic chk(input string nm, input logic [P_W-1:0] exp, input logic [P_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // single place where the run ends
  task automatic final_report();
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // wait n rising edges, then look once the updates have landed
  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : edges
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // watchdog, far beyond the 50 or so cycles the tests take
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    {a, acin, b, bcin, c, d, cin, csel, im, alu, rs} = '0;
    op = 9'h001;
    en = '1;
    resetn = 1'b0;
    edges(12);
    chk("p_in_reset", '0, p);
    @(negedge sys_clk);
    resetn = 1'b1;
    // a and b through two stages, multiplier and output register
    foreach (rows[i]) begin
      @(negedge sys_clk);
      {a, b} = rows[i][A_W+B_W+P_W-1:P_W];
      edges(2);
      chk("acout", a, acout);
      chk("bcout", b, bcout);
      edges(2);
      chk("p", rows[i][P_W-1:0], p);
      chk("pcout", rows[i][P_W-1:0], pcout);
    end
    // first a stage stalled: the tap keeps the old operand
    @(negedge sys_clk);
    en[0] = 1'b0;
    a = 30'h155;
    edges(3);
    chk("acout_hold", 30'h3E8, acout);
    // a reset clears the a chain; acout shows the second stage, whose enable is high
    @(negedge sys_clk);
    rs[0] = 1'b1;
    edges(1);
    chk("acout_rst", '0, acout);
    @(negedge sys_clk);
    rs[0] = 1'b0;
    en[0] = 1'b1;
    // c operand routed to the result: c register plus output register
    op = 9'h030;
    c = 58'h2AA_5555;
    edges(2);
    chk("p_from_c", 58'h2AA_5555, p);
    // output register cleared by its own reset
    @(negedge sys_clk);
    rs[4] = 1'b1;
    edges(1);
    chk("p_rst", '0, p);
    // global reset clears the c register too
    @(negedge sys_clk);
    rs[4] = 1'b0;
    rs[10] = 1'b1;
    edges(1);
    @(negedge sys_clk);
    rs[10] = 1'b0;
    en[4] = 1'b0;
    // second edge lets p show the still-cleared c register
    edges(2);
    chk("p_glb", '0, p);
    // c plus c overflows the full-width adder into carry bit 0
    @(negedge sys_clk);
    en[4] = 1'b1;
    c = 58'h200_0000_0000_0000;
    op = 9'h034;
    edges(2);
    chk("carryout", 4'h1, co);
    chk("p_wrap", '0, p);
    // result goes round the neighbour and comes back on pcin
    @(negedge sys_clk);
    c = 58'h155;
    op = 9'h030;
    edges(2);
    @(negedge sys_clk);
    c = '0;
    op = 9'h010;
    edges(2);
    chk("p_from_pcin", 58'h155, p);
    // output enable low: p holds while its inputs move
    @(negedge sys_clk);
    en[6] = 1'b0;
    op = 9'h030;
    c = 58'h3;
    edges(2);
    chk("p_hold", 58'h155, p);
    // control reset clears opmode; control enable low keeps it clear
    @(negedge sys_clk);
    en[6] = 1'b1;
    rs[7] = 1'b1;
    edges(1);
    @(negedge sys_clk);
    rs[7] = 1'b0;
    en[9] = 1'b0;
    edges(2);
    chk("p_ctrl_rst", '0, p);
    final_report();
  end
endmodule : mac_slice_pipeline_regs_test
`default_nettype wire
